// [hdl/ir_remote_pkg.sv]
// constants for the infrared remote unit and its interrupt-controller slice
package ir_remote_pkg;
    // ==========================================================
    // register map (byte addresses, 8-bit registers)
    localparam logic [15:0] ir_config_addr = 16'h5340;
    localparam logic [15:0] ir_clock_select_addr = 16'h5341;
    localparam logic [15:0] carrier_high_length_addr = 16'h5342;
    localparam logic [15:0] carrier_low_length_addr = 16'h5343;
    localparam logic [15:0] ir_data_bit_addr = 16'h5344;
    localparam logic [15:0] pulse_length_counter_addr = 16'h5345;
    localparam logic [15:0] ir_irq_mask_addr = 16'h5346;
    localparam logic [15:0] ir_irq_flags_addr = 16'h5347;
    // interrupt controller slice
    localparam logic [15:0] ctrl_flag_addr = 16'h4300;
    localparam logic [15:0] ctrl_enable_addr = 16'h4302;
    localparam logic [15:0] ctrl_level_addr = 16'h4312;
    localparam int ctrl_unit_bit = 13;
    localparam int ctrl_level_lsb = 8;
    // ==========================================================
    // field positions
    localparam int enable_bit = 0;
    localparam int direction_bit = 1;
    localparam int underflow_bit = 0;
    localparam int rise_bit = 1;
    localparam int fall_bit = 2;
    localparam int carrier_sel_lsb = 4;
    localparam int counter_sel_lsb = 0;
    // ==========================================================
    // masks and reset values
    localparam logic [7:0] config_mask = 8'h03;
    localparam logic [7:0] flag_mask = 8'h07;
    localparam logic [7:0] carrier_len_mask = 8'h3F;
    localparam logic [7:0] data_bit_mask = 8'h01;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam logic [3:0] reserved_select = 4'hF;
    localparam logic [2:0] level_reset = 3'h0;
    // ==========================================================
    // vector
    localparam logic [7:0] unit_vector_number = 8'h11;
    localparam logic [15:0] unit_vector_address = 16'h8044;
    // ==========================================================
    // edge filter: level must be seen on this many sample ticks
    localparam logic [1:0] filter_samples = 2'h2;
endpackage : ir_remote_pkg

// [hdl/ir_remote_unit.sv]
// infrared remote unit: registers, prescaler, edge and underflow events
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps

// Notes on behaviour
// - falling edge on receive pin sets falling-edge flag bit 2
// - falling-edge enable low: flag never set, no request from it
// - any enabled flag set drives request line to controller flag
// - writing one clears a flag; handler clears both flags
// - controller flag bit 13 set on every request, enable ignored
// - request reaches core only while controller enable bit 13 is one
// - three-bit level field bits 10:8 gives priority zero to seven
// - core accepts if enabled, core enable, level above current, none higher
// - interrupt uses vector 17 at address 0x8044
// - eight byte registers from 0x5340 to 0x5347
// - configuration bit 1 picks receive when one, resets to zero
// - configuration bit 0 enables unit, clearing stops all, resets zero
// - carrier clock is peripheral clock over two to the code
// - counter clock select uses the same divide encoding
// - counter clock select sits in bits 3:0
// - counter reaching zero sets underflow flag bit 0 if enabled
// - rising edge sets rise flag bit 1 if enabled
// - edge counts only when new level held two sample ticks
module ir_remote_unit (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [7:0] writedata,
    output logic [7:0] readdata,
    output logic waitrequest,
    input wire logic ir_receive_pin,
    output logic ir_transmit_pin,
    input wire logic core_irq_enable_bit,
    input wire logic [2:0] core_level_field,
    input wire logic higher_pending,
    output logic unit_request,
    output logic core_irq_take,
    output logic [7:0] core_vector_number,
    output logic [15:0] core_vector_address
);
    // ==========================================================
    // registers
    logic [7:0] ir_config;
    logic [7:0] ir_clock_select;
    logic [5:0] carrier_high_length;
    logic [5:0] carrier_low_length;
    logic ir_data_bit;
    logic [7:0] pulse_length_count;
    logic [2:0] ir_irq_mask;
    logic [2:0] ir_irq_flags;
    logic ctrl_unit_flag;
    logic ctrl_unit_enable;
    logic [2:0] ctrl_unit_level;
    logic [13:0] prescaler;
    logic carrier_tick;
    logic counter_tick;
    logic [1:0] sample_hist;
    logic filtered_level;
    logic filter_armed;
    logic rise_event;
    logic fall_event;
    logic underflow_event;
    logic [5:0] carrier_count;
    logic carrier_phase;
    logic bus_ack;
    logic any_flag;
    logic wr_go;

    logic unit_on;
    logic receiving;
    assign unit_on = ir_config[ir_remote_pkg::enable_bit];
    assign receiving = ir_config[ir_remote_pkg::direction_bit];
    // one-cycle bus answer: waitrequest low in the cycle after request
    assign wr_go = write && bus_ack;
    // decode a prescaler code into a tick of clk / 2**code
    function automatic logic tick_of(input logic [3:0] code,
                                     input logic [13:0] pre);
        logic t;
        t = 1'b0;
        if (code == 4'h0)
            t = 1'b1;
        else if (code != ir_remote_pkg::reserved_select)
            t = (pre & ((14'h0001 << code) - 14'h0001)) == 14'h0000;
        return t;
    endfunction : tick_of

    // ==========================================================
    // bus slave
    always_ff @(posedge clk)
    begin
        if (srst)
            waitrequest <= 1'b1;
        else if (clk_en)
            waitrequest <= !((read || write) && waitrequest);
    end
    assign bus_ack = !waitrequest;

    always_ff @(posedge clk)
    begin
        if (srst)
            readdata <= ir_remote_pkg::reg_reset;
        else if (clk_en && read && !bus_ack)
        begin
            case (address)
                ir_remote_pkg::ir_config_addr:
                    readdata <= ir_config & ir_remote_pkg::config_mask;
                ir_remote_pkg::ir_clock_select_addr:
                    readdata <= ir_clock_select;
                ir_remote_pkg::carrier_high_length_addr:
                    readdata <= {2'h0, carrier_high_length};
                ir_remote_pkg::carrier_low_length_addr:
                    readdata <= {2'h0, carrier_low_length};
                ir_remote_pkg::ir_data_bit_addr:
                    readdata <= {7'h00, ir_data_bit};
                ir_remote_pkg::pulse_length_counter_addr:
                    readdata <= pulse_length_count;
                ir_remote_pkg::ir_irq_mask_addr:
                    readdata <= {5'h00, ir_irq_mask};
                ir_remote_pkg::ir_irq_flags_addr:
                    readdata <= {5'h00, ir_irq_flags};
                ir_remote_pkg::ctrl_flag_addr:
                    readdata <= {2'h0, ctrl_unit_flag, 5'h00};
                ir_remote_pkg::ctrl_enable_addr:
                    readdata <= {2'h0, ctrl_unit_enable, 5'h00};
                ir_remote_pkg::ctrl_level_addr:
                    readdata <= {5'h00, ctrl_unit_level};
                default:
                    readdata <= ir_remote_pkg::reg_reset;
            endcase
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ir_config <= ir_remote_pkg::reg_reset;
            ir_clock_select <= ir_remote_pkg::reg_reset;
            carrier_high_length <= 6'h00;
            carrier_low_length <= 6'h00;
            ir_irq_mask <= 3'h0;
            ctrl_unit_enable <= 1'b0;
            ctrl_unit_level <= ir_remote_pkg::level_reset;
        end
        else if (clk_en && wr_go)
        begin
            case (address)
                ir_remote_pkg::ir_config_addr:
                    ir_config <= writedata & ir_remote_pkg::config_mask;
                ir_remote_pkg::ir_clock_select_addr:
                    ir_clock_select <= writedata;
                ir_remote_pkg::carrier_high_length_addr:
                    carrier_high_length <= writedata[5:0];
                ir_remote_pkg::carrier_low_length_addr:
                    carrier_low_length <= writedata[5:0];
                ir_remote_pkg::ir_irq_mask_addr:
                    ir_irq_mask <= writedata[2:0];
                ir_remote_pkg::ctrl_enable_addr:
                    ctrl_unit_enable <= writedata[5];
                ir_remote_pkg::ctrl_level_addr:
                    ctrl_unit_level <= writedata[2:0];
                default:
                    ir_config <= ir_config;
            endcase
        end
    end

    // ==========================================================
    // prescaler and clock selects
    always_ff @(posedge clk)
    begin
        if (srst || (clk_en && !unit_on))
            prescaler <= 14'h0000;
        else if (clk_en)
            prescaler <= prescaler + 14'h0001;
    end
    assign carrier_tick = unit_on &&
        tick_of(ir_clock_select[ir_remote_pkg::carrier_sel_lsb +: 4],
                prescaler);
    assign counter_tick = unit_on &&
        tick_of(ir_clock_select[ir_remote_pkg::counter_sel_lsb +: 4],
                prescaler);

    // ==========================================================
    // receive edge filter on carrier clock samples
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sample_hist <= 2'h0;
            filtered_level <= 1'b0;
            filter_armed <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!(unit_on && receiving))
                filter_armed <= 1'b0;
            else if (carrier_tick)
            begin
                sample_hist <= {sample_hist[0], ir_receive_pin};
                if (sample_hist[0] == ir_receive_pin)
                begin
                    filtered_level <= ir_receive_pin;
                    filter_armed <= 1'b1;
                end
            end
        end
    end
    assign rise_event = unit_on && receiving && carrier_tick &&
        filter_armed && sample_hist[0] && ir_receive_pin && !filtered_level;
    assign fall_event = unit_on && receiving && carrier_tick &&
        filter_armed && !sample_hist[0] && !ir_receive_pin && filtered_level;

    // ==========================================================
    // data bit and length counter
    always_ff @(posedge clk)
    begin
        if (srst)
            ir_data_bit <= 1'b0;
        else if (clk_en && unit_on && receiving && carrier_tick &&
                 sample_hist[0] == ir_receive_pin)
            ir_data_bit <= ir_receive_pin;
        else if (clk_en && wr_go && address == ir_remote_pkg::ir_data_bit_addr)
            ir_data_bit <= writedata[0];
    end

    assign underflow_event = counter_tick && pulse_length_count == 8'h01;
    always_ff @(posedge clk)
    begin
        if (srst)
            pulse_length_count <= ir_remote_pkg::reg_reset;
        else if (clk_en && wr_go &&
                 address == ir_remote_pkg::pulse_length_counter_addr)
            pulse_length_count <= writedata;
        else if (clk_en && counter_tick && pulse_length_count != 8'h00)
            pulse_length_count <= pulse_length_count - 8'h01;
    end

    // ==========================================================
    // carrier modulated transmit output
    always_ff @(posedge clk)
    begin
        if (srst || (clk_en && !(unit_on && !receiving)))
        begin
            carrier_count <= 6'h00;
            carrier_phase <= 1'b1;
        end
        else if (clk_en && carrier_tick)
        begin
            if (carrier_count == (carrier_phase ? carrier_high_length
                                                : carrier_low_length))
            begin
                carrier_count <= 6'h00;
                carrier_phase <= !carrier_phase;
            end
            else
                carrier_count <= carrier_count + 6'h01;
        end
    end
    always_ff @(posedge clk)
    begin
        if (srst)
            ir_transmit_pin <= 1'b0;
        else if (clk_en)
            ir_transmit_pin <= unit_on && !receiving && ir_data_bit &&
                carrier_phase;
    end

    // ==========================================================
    // flags; set wins over clear
    always_ff @(posedge clk)
    begin
        if (srst)
            ir_irq_flags <= 3'h0;
        else if (clk_en)
        begin
            ir_irq_flags <= (ir_irq_flags &
                ~((wr_go && address == ir_remote_pkg::ir_irq_flags_addr)
                  ? writedata[2:0] : 3'h0)) |
                (ir_irq_mask & {fall_event, rise_event, underflow_event});
        end
    end

    // ==========================================================
    // request line
    assign any_flag = |(ir_irq_flags & ir_irq_mask);
    always_ff @(posedge clk)
    begin
        if (srst)
            unit_request <= 1'b0;
        else if (clk_en)
            unit_request <= any_flag;
    end

    // controller flag, set wins over clear
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_unit_flag <= 1'b0;
        else if (clk_en)
            ctrl_unit_flag <= unit_request || (ctrl_unit_flag &&
                !(wr_go && address == ir_remote_pkg::ctrl_flag_addr &&
                  writedata[5]));
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            core_irq_take <= 1'b0;
            core_vector_number <= 8'h00;
            core_vector_address <= 16'h0000;
        end
        else if (clk_en)
        begin
            core_irq_take <= ctrl_unit_flag && ctrl_unit_enable &&
                core_irq_enable_bit && ctrl_unit_level > core_level_field &&
                !higher_pending;
            core_vector_number <= ir_remote_pkg::unit_vector_number;
            core_vector_address <= ir_remote_pkg::unit_vector_address;
        end
    end

    // ==========================================================
    // checks
    // masked fall
    a_fall_masked: assert property (@(posedge clk) disable iff (srst)
        clk_en && !ir_irq_mask[2] && !ir_irq_flags[2] |=> !ir_irq_flags[2])
        else $error("fall flag set while masked");
    a_request_follow: assert property (@(posedge clk) disable iff (srst)
        clk_en && any_flag |=> unit_request)
        else $error("request missing");
    a_ctrl_flag_set: assert property (@(posedge clk) disable iff (srst)
        clk_en && unit_request |=> ctrl_unit_flag)
        else $error("controller flag not set");
    a_core_gate: assert property (@(posedge clk) disable iff (srst)
        core_irq_take |-> $past(ctrl_unit_enable))
        else $error("take without enable");
    a_off_quiet: assert property (@(posedge clk) disable iff (srst)
        clk_en && !unit_on |=> (ir_irq_flags & ~$past(ir_irq_flags)) == 3'h0)
        else $error("event while disabled");
    a_underflow_set: assert property (@(posedge clk) disable iff (srst)
        clk_en && underflow_event && ir_irq_mask[0] |=> ir_irq_flags[0])
        else $error("underflow flag missing");
    a_fall_set: assert property (@(posedge clk) disable iff (srst)
        clk_en && fall_event && ir_irq_mask[2] |=> ir_irq_flags[2])
        else $error("fall flag missing");
    a_config_zero: assert property (@(posedge clk) disable iff (srst)
        (ir_config & ~ir_remote_pkg::config_mask) == 8'h00)
        else $error("reserved config bit set");
endmodule : ir_remote_unit

// [test/ir_receiver_model.sv]
// demodulating receiver model driving the unit's receive input
`timescale 1ns/1ps

module ir_receiver_model (
    input wire logic clk,
    output logic ir_receive_pin
);
    // ==========================================================
    // line idles high between pulses
    initial ir_receive_pin = 1'b1;

    // ==========================================================
    // level held for a number of clock edges
    // one-edge hold is noise
    task automatic send(input logic level, input int cycles);
        begin
            ir_receive_pin <= level;
            repeat (cycles) @(posedge clk);
        end
    endtask : send
endmodule : ir_receiver_model

// [test/ir_remote_unit_tb_top.sv]
// self-checking bench for the infrared remote unit
`timescale 1ns/1ps

module ir_remote_unit_tb_top;
    typedef struct {logic [7:0] value; string what;} note_type;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [15:0] address = 16'h0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] writedata = 8'h00;
    logic [7:0] readdata;
    logic waitrequest;
    logic ir_receive_pin;
    logic ir_transmit_pin;
    logic core_irq_enable_bit = 1'b0;
    logic [2:0] core_level_field = 3'h0;
    logic higher_pending = 1'b0;
    logic unit_request;
    logic core_irq_take;
    logic [7:0] core_vector_number;
    logic [15:0] core_vector_address;
    int n_errors = 0;
    int total_checks = 0;
    note_type notes[$];
    note_type seen_note;

    always #2.5 clk = ~clk;

    ir_remote_unit i_dut (
        .clk(clk),
        .srst(srst),
        .clk_en(clk_en),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .ir_receive_pin(ir_receive_pin),
        .ir_transmit_pin(ir_transmit_pin),
        .core_irq_enable_bit(core_irq_enable_bit),
        .core_level_field(core_level_field),
        .higher_pending(higher_pending),
        .unit_request(unit_request),
        .core_irq_take(core_irq_take),
        .core_vector_number(core_vector_number),
        .core_vector_address(core_vector_address)
    );

    ir_receiver_model i_model (
        .clk(clk),
        .ir_receive_pin(ir_receive_pin)
    );

    // ==========================================================
    // comparison and closing
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] seen);
        begin
            total_checks++;
            if (seen !== exp)
            begin
                n_errors++;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask : check

    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask : finish_test

    // ==========================================================
    // avalon master: hold until waitrequest sampled low
    task automatic bus(input logic wr, input logic [15:0] a,
        input logic [7:0] d);
        int n;
        begin
            n = 0;
            address <= a;
            writedata <= d;
            write <= wr;
            read <= ~wr;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (waitrequest !== 1'b0 && n < 50);
            if (waitrequest !== 1'b0)
            begin
                n_errors++;
                finish_test();
            end
            write <= 1'b0;
            read <= 1'b0;
            @(posedge clk);
        end
    endtask : bus

    task automatic rd(input logic [15:0] a, input logic [7:0] exp,
        input string what);
        note_type n;
        begin
            n.value = exp;
            n.what = what;
            notes.push_back(n);
            bus(1'b0, a, 8'h00);
        end
    endtask : rd

    // bounded wait on request (0) or core take (1)
    task automatic wait_out(input bit which, input logic exp,
        input string what);
        int n;
        logic seen;
        begin
            n = 0;
            seen = which ? core_irq_take : unit_request;
            while (seen !== exp && n < 40)
            begin
                @(posedge clk);
                n++;
                seen = which ? core_irq_take : unit_request;
            end
            check(what, {15'h0000, exp}, {15'h0000, seen});
            if (seen !== exp)
                finish_test();
        end
    endtask : wait_out

    // ==========================================================
    // read monitor: oldest note against returned data
    always @(posedge clk)
    begin
        if (read === 1'b1 && waitrequest === 1'b0)
        begin
            seen_note = notes.pop_front();
            check(seen_note.what, {8'h00, seen_note.value},
                {8'h00, readdata});
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [7:0] sel;
        logic [5:0] cond [6];
        cond = '{6'b1_011_0_0, 6'b1_010_0_1, 6'b1_010_1_0,
            6'b1_010_0_1, 6'b0_010_0_0, 6'b1_010_0_1};
        void'($urandom(31));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(ir_remote_pkg::ir_config_addr, 8'h00, "config");
        rd(ir_remote_pkg::ir_clock_select_addr, 8'h00, "clksel");
        rd(ir_remote_pkg::ir_irq_mask_addr, 8'h00, "mask");
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h00, "flags");
        rd(16'h5348, 8'h00, "unmapped");
        check("vector", 16'h0011, {8'h00, core_vector_number});
        check("vector addr", 16'h8044, core_vector_address);
        bus(1'b1, ir_remote_pkg::carrier_high_length_addr, 8'hFF);
        rd(ir_remote_pkg::carrier_high_length_addr, 8'h3F, "carh");
        bus(1'b1, ir_remote_pkg::ir_data_bit_addr, 8'hFF);
        rd(ir_remote_pkg::ir_data_bit_addr, 8'h01, "data bit");
        bus(1'b1, ir_remote_pkg::ir_irq_mask_addr, 8'hFF);
        rd(ir_remote_pkg::ir_irq_mask_addr, 8'h07, "mask rsv");
        bus(1'b1, ir_remote_pkg::ir_irq_mask_addr, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            sel = {4'($urandom_range(14)), 4'($urandom_range(14))};
            bus(1'b1, ir_remote_pkg::ir_clock_select_addr, sel);
            rd(ir_remote_pkg::ir_clock_select_addr, sel, "clksel");
        end
        bus(1'b1, ir_remote_pkg::ir_clock_select_addr, 8'h00);
        bus(1'b1, ir_remote_pkg::ir_config_addr, 8'h03);
        rd(ir_remote_pkg::ir_config_addr, 8'h03, "config rx");
        i_model.send(1'b1, 6);
        i_model.send(1'b0, 8);
        i_model.send(1'b1, 8);
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h00, "masked");
        wait_out(0, 1'b0, "masked req");
        bus(1'b1, ir_remote_pkg::ir_irq_mask_addr, 8'h04);
        i_model.send(1'b0, 1);
        i_model.send(1'b1, 8);
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h00, "glitch");
        i_model.send(1'b0, 8);
        wait_out(0, 1'b1, "fall req");
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h04, "fall flag");
        rd(ir_remote_pkg::ctrl_flag_addr, 8'h20, "ctrl flag");
        bus(1'b1, ir_remote_pkg::ctrl_level_addr, 8'h03);
        rd(ir_remote_pkg::ctrl_level_addr, 8'h03, "level");
        core_irq_enable_bit <= 1'b1;
        core_level_field <= 3'h2;
        repeat (2) @(posedge clk);
        wait_out(1, 1'b0, "take off");
        bus(1'b1, ir_remote_pkg::ctrl_enable_addr, 8'h20);
        wait_out(1, 1'b1, "take on");
        for (int i = 0; i < 6; i++)
        begin
            core_irq_enable_bit <= cond[i][5];
            core_level_field <= cond[i][4:2];
            higher_pending <= cond[i][1];
            @(posedge clk);
            wait_out(1, cond[i][0], "take cond");
        end
        bus(1'b1, ir_remote_pkg::ir_irq_flags_addr, 8'h04);
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h00, "fall clr");
        wait_out(0, 1'b0, "req clr");
        bus(1'b1, ir_remote_pkg::ctrl_flag_addr, 8'h20);
        rd(ir_remote_pkg::ctrl_flag_addr, 8'h00, "ctrl clr");
        wait_out(1, 1'b0, "take clr");
        bus(1'b1, ir_remote_pkg::ir_irq_mask_addr, 8'h02);
        i_model.send(1'b1, 8);
        wait_out(0, 1'b1, "rise req");
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h02, "rise flag");
        bus(1'b1, ir_remote_pkg::ir_irq_flags_addr, 8'h02);
        bus(1'b1, ir_remote_pkg::ir_irq_mask_addr, 8'h01);
        bus(1'b1, ir_remote_pkg::pulse_length_counter_addr, 8'h03);
        // frozen clock enable must hold the count
        clk_en <= 1'b0;
        repeat (10) @(posedge clk);
        check("frozen req", 16'h0000, {15'h0000, unit_request});
        clk_en <= 1'b1;
        wait_out(0, 1'b1, "under req");
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h01, "under flag");
        bus(1'b1, ir_remote_pkg::ir_irq_flags_addr, 8'h01);
        bus(1'b1, ir_remote_pkg::ir_irq_mask_addr, 8'h06);
        bus(1'b1, ir_remote_pkg::ir_config_addr, 8'h00);
        i_model.send(1'b0, 8);
        i_model.send(1'b1, 8);
        rd(ir_remote_pkg::ir_irq_flags_addr, 8'h00, "disabled");
        wait_out(0, 1'b0, "off req");
        // transmit mode: data bit modulated onto carrier high phase
        bus(1'b1, ir_remote_pkg::ir_data_bit_addr, 8'h01);
        bus(1'b1, ir_remote_pkg::ir_config_addr, 8'h01);
        repeat (2) @(posedge clk);
        check("tx high", 16'h0001, {15'h0000, ir_transmit_pin});
        bus(1'b1, ir_remote_pkg::ir_data_bit_addr, 8'h00);
        repeat (2) @(posedge clk);
        check("tx low", 16'h0000, {15'h0000, ir_transmit_pin});
        bus(1'b1, ir_remote_pkg::ir_config_addr, 8'h00);
        finish_test();
    end
endmodule : ir_remote_unit_tb_top
